// >>> rtl/cmd_status_pkg.sv
// constants and carrier types for the primary command/status bits
// assumes a single core clock and dword-wide configuration accesses
package cmd_status_pkg;
  localparam logic [11:0] CMD_STATUS_OFFSET = 12'h004;
  localparam int CFG_ADDR_W = 12;
  localparam int CFG_DATA_W = 32;
  // command field positions
  localparam int PALETTE_SNOOP_BIT = 5;
  localparam int PARITY_RESP_BIT = 6;
  localparam int WAIT_CYCLE_BIT = 7;
  localparam int SERR_ENABLE_BIT = 8;
  localparam int FAST_B2B_EN_BIT = 9;
  localparam int INTX_DISABLE_BIT = 10;
  // status field positions
  localparam int INTX_PENDING_BIT = 19;
  localparam int CAP_LIST_BIT = 20;
  localparam int CAP_66MHZ_BIT = 21;
  localparam int FAST_B2B_CAP_BIT = 23;
  localparam int MDPE_BIT = 24;
  // byte lanes of the writable fields
  localparam int PARITY_RESP_LANE = 0;
  localparam int CMD_HIGH_LANE = 1;
  localparam int MDPE_LANE = 3;
  // values after reset
  localparam logic PARITY_RESP_RESET = 1'b0;
  localparam logic SERR_ENABLE_RESET = 1'b0;
  localparam logic INTX_DISABLE_RESET = 1'b0;
  localparam logic INTX_PENDING_RESET = 1'b0;
  localparam logic MDPE_RESET = 1'b0;
  localparam logic CAP_LIST_VALUE = 1'b1;
  localparam logic [31:0] RD_DATA_RESET = 32'h0000_0000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] data;
  } cfg_req_type;

  typedef struct packed {
    logic forward_err;
    logic reverse_err;
  } err_event_type;
endpackage

// >>> rtl/primary_command_status_bits.sv
// primary command bits 10:5 and status bits 24:19 of the config dword at 04h
// assumes config requests are one-cycle strobes synchronous to core_clk_in
//
// What this block does
// R1: palette snoop enable bit 5 is read-only zero and snooping never happens.
// R2: with bit 6 set, a poisoned TLP or parity error sets the parity error flag.
// R3: with bit 6 clear, parity errors leave the status flag alone.
// R4: wait cycle control bit 7 is read-only zero.
// R5: forward mode sends error messages only while bit 8 is set.
// R6: reverse mode drives the system error pin only while bit 8 is set.
// R7: fast back-to-back enable bit 9 is read-only zero.
// R8: bit 10 set blocks and releases INTx; it resets to zero.
// R9: status bit 19 reads one while an INTx request is pending.
// R10: status bit 20 always reads one for the capability list.
// R11: status bit 21 resets to zero forward and one reverse.
// R12: status bit 23 is one only in reverse mode with a conventional PCI primary.
// R13: status bit 24 is the parity error flag, cleared by writing one.
// R14: reserved status bits 18:16 and 22 read zero and ignore writes.
`timescale 1ns/1ps
module primary_command_status_bits (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire cmd_status_pkg::cfg_req_type cfg_req_in,
  input wire logic reverse_mode_in,
  input wire logic primary_pci_mode_in,
  input wire logic parity_event_in,
  input wire cmd_status_pkg::err_event_type err_event_in,
  input wire logic intx_request_in,
  output logic [31:0] rd_data_out,
  output logic rd_valid_out,
  output logic parity_resp_en_out,
  output logic err_msg_out,
  output logic system_error_pin_n_out,
  output logic system_error_pin_n_oe_out,
  output logic intx_assert_out
);
  import cmd_status_pkg::*;

  logic par_resp_reg;
  logic serr_en_reg;
  logic intx_dis_reg;
  logic mdpe_reg;
  logic pend_reg;
  logic cap66_reg;
  logic fb2b_reg;
  logic [31:0] rd_data_reg;
  logic rd_valid_reg;
  logic err_msg_reg;
  logic serr_oe_reg;
  logic intx_out_reg;
  logic serr_val_reg;

  // decode
  wire hit = cfg_req_in.addr == CMD_STATUS_OFFSET;
  wire wr_hit = cfg_req_in.wr && hit;
  wire rd_hit = cfg_req_in.rd && hit;
  wire wr_lane0 = wr_hit && cfg_req_in.be[PARITY_RESP_LANE];
  wire wr_lane1 = wr_hit && cfg_req_in.be[CMD_HIGH_LANE];
  wire wr_lane3 = wr_hit && cfg_req_in.be[MDPE_LANE];

  wire par_resp_next = wr_lane0 ? cfg_req_in.data[PARITY_RESP_BIT] : par_resp_reg;
  wire serr_en_next = wr_lane1 ? cfg_req_in.data[SERR_ENABLE_BIT] : serr_en_reg;
  wire intx_dis_next = wr_lane1 ? cfg_req_in.data[INTX_DISABLE_BIT] : intx_dis_reg;

  // parity flag: set wins over write-one-clear
  wire mdpe_set = parity_event_in && par_resp_reg; // R2 R3
  wire mdpe_clr = wr_lane3 && cfg_req_in.data[MDPE_BIT]; // R13
  wire mdpe_next = mdpe_set || (mdpe_reg && !mdpe_clr); // R13

  // error reporting gates
  wire err_msg_next = err_event_in.forward_err && serr_en_reg && !reverse_mode_in; // R5
  wire serr_drive_next = err_event_in.reverse_err && serr_en_reg && reverse_mode_in; // R6
  wire intx_next = intx_request_in && !intx_dis_reg; // R8
  wire fb2b_next = reverse_mode_in && primary_pci_mode_in; // R12

  // read image: bits 5, 7, 9, 18:16, 22 and everything outside the block are zero
  logic [31:0] rd_image;
  always_comb begin
    rd_image = 32'h0000_0000; // R1 R4 R7 R14
    rd_image[PARITY_RESP_BIT] = par_resp_reg;
    rd_image[SERR_ENABLE_BIT] = serr_en_reg;
    rd_image[INTX_DISABLE_BIT] = intx_dis_reg;
    rd_image[INTX_PENDING_BIT] = pend_reg; // R9
    rd_image[CAP_LIST_BIT] = CAP_LIST_VALUE; // R10
    rd_image[CAP_66MHZ_BIT] = cap66_reg; // R11
    rd_image[FAST_B2B_CAP_BIT] = fb2b_reg; // R12
    rd_image[MDPE_BIT] = mdpe_reg; // R13
  end
  wire [31:0] rd_data_next = rd_hit ? rd_image : RD_DATA_RESET;

  // command bits
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      par_resp_reg <= PARITY_RESP_RESET; // R2
      serr_en_reg <= SERR_ENABLE_RESET; // R5
      intx_dis_reg <= INTX_DISABLE_RESET; // R8
    end else begin
      par_resp_reg <= par_resp_next; // R2
      serr_en_reg <= serr_en_next; // R5 R6
      intx_dis_reg <= intx_dis_next; // R8
    end
  end

  // status bits; 66MHz strap caught while reset is held
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      mdpe_reg <= MDPE_RESET;
      pend_reg <= INTX_PENDING_RESET;
      cap66_reg <= reverse_mode_in; // R11
      fb2b_reg <= fb2b_next; // R12
    end else begin
      mdpe_reg <= mdpe_next; // R2 R13
      pend_reg <= intx_request_in; // R9
      fb2b_reg <= fb2b_next; // R12
    end
  end

  // read port and primary side outputs
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rd_data_reg <= RD_DATA_RESET;
      rd_valid_reg <= 1'b0;
      err_msg_reg <= 1'b0;
      serr_oe_reg <= 1'b0;
      serr_val_reg <= 1'b1;
      intx_out_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_hit;
      err_msg_reg <= err_msg_next; // R5
      serr_oe_reg <= serr_drive_next; // R6
      serr_val_reg <= !serr_drive_next; // R6
      intx_out_reg <= intx_next; // R8
    end
  end

  assign rd_data_out = rd_data_reg;
  assign rd_valid_out = rd_valid_reg;
  assign parity_resp_en_out = par_resp_reg;
  assign err_msg_out = err_msg_reg;
  assign system_error_pin_n_out = serr_val_reg;
  assign system_error_pin_n_oe_out = serr_oe_reg;
  assign intx_assert_out = intx_out_reg;

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  a_palette_bit_zero: assert property ( // R1
    rd_valid_out |-> !rd_data_out[PALETTE_SNOOP_BIT])
    else $error("palette snoop bit read as one");

  a_parity_flag_set: assert property ( // R2
    (parity_event_in && par_resp_reg) |=> mdpe_reg)
    else $error("parity flag not set while response enabled");

  a_parity_flag_held: assert property ( // R3
    (!mdpe_reg && !par_resp_reg) |=> !mdpe_reg)
    else $error("parity flag set with response disabled");

  a_wait_bit_zero: assert property ( // R4
    rd_valid_out |-> !rd_data_out[WAIT_CYCLE_BIT] && !rd_data_out[FAST_B2B_EN_BIT])
    else $error("unsupported command bit read as one");

  a_err_msg_gate: assert property ( // R5
    err_msg_out |-> $past(serr_en_reg) && !$past(reverse_mode_in))
    else $error("error message sent while disabled");

  a_serr_pin_gate: assert property ( // R6
    (err_event_in.reverse_err && serr_en_reg && reverse_mode_in)
      |=> system_error_pin_n_oe_out && !system_error_pin_n_out)
    else $error("system error pin not driven");

  a_serr_pin_quiet: assert property ( // R6
    (!serr_en_reg) |=> !system_error_pin_n_oe_out)
    else $error("system error pin driven while disabled");

  a_intx_release: assert property ( // R8
    intx_dis_reg |=> !intx_assert_out)
    else $error("intx asserted while disabled");

  a_pending_status: assert property ( // R9
    (rd_hit && pend_reg) |=> rd_data_out[INTX_PENDING_BIT])
    else $error("pending status missing");

  a_cap_list_one: assert property ( // R10
    rd_valid_out |-> rd_data_out[CAP_LIST_BIT])
    else $error("capability list bit read as zero");

  a_cap66_stable: assert property ( // R11
    !$rose(srst_in) |-> $stable(cap66_reg))
    else $error("66MHz flag changed outside reset");

  a_fb2b_mode: assert property ( // R12
    (rd_hit && fb2b_reg) |=> rd_data_out[FAST_B2B_CAP_BIT] && $past(reverse_mode_in, 2))
    else $error("fast back-to-back capability wrong");

  a_parity_clear: assert property ( // R13
    (mdpe_reg && mdpe_clr && !mdpe_set) |=> !mdpe_reg ##1 (mdpe_reg == $past(mdpe_set)))
    else $error("parity flag clear misbehaved");

  a_reserved_zero: assert property ( // R14
    rd_valid_out |-> rd_data_out[18:16] == 3'h0 && !rd_data_out[22])
    else $error("reserved status bits read nonzero");

  a_cmd_reset_zero: assert property ( // R2 R5 R8
    $fell(srst_in)
      |-> !par_resp_reg && !serr_en_reg && !intx_dis_reg)
    else $error("command bits not zero after reset");

  a_status_reset_zero: assert property ( // R9 R13
    $fell(srst_in)
      |-> !mdpe_reg && !pend_reg)
    else $error("status flags not zero after reset");

  a_outputs_reset_quiet: assert property ( // R5 R6 R8
    $fell(srst_in)
      |-> !rd_valid_out && !err_msg_out && !system_error_pin_n_oe_out && !intx_assert_out)
    else $error("outputs active after reset");

  a_cap66_strap: assert property ( // R11
    $fell(srst_in)
      |-> cap66_reg == $past(reverse_mode_in))
    else $error("66MHz flag does not follow bridge mode");

  a_cap66_read: assert property ( // R11
    rd_hit
      |=> rd_data_out[CAP_66MHZ_BIT] == $past(reverse_mode_in))
    else $error("66MHz flag read wrong");

  a_fb2b_source: assert property ( // R12
    fb2b_reg
      |-> $past(reverse_mode_in) && $past(primary_pci_mode_in))
    else $error("fast back-to-back capability set outside reverse PCI mode");

  a_fb2b_zero_read: assert property ( // R12
    (rd_hit && !fb2b_reg)
      |=> !rd_data_out[FAST_B2B_CAP_BIT])
    else $error("fast back-to-back capability read as one");

  a_cmd_read_back: assert property ( // R2 R5 R8
    rd_hit |=> rd_data_out[PARITY_RESP_BIT] == $past(par_resp_reg)
      && rd_data_out[SERR_ENABLE_BIT] == $past(serr_en_reg)
      && rd_data_out[INTX_DISABLE_BIT] == $past(intx_dis_reg))
    else $error("command bits read back wrong");

  a_parity_resp_on: assert property ( // R2
    (wr_lane0 && cfg_req_in.data[PARITY_RESP_BIT])
      |=> parity_resp_en_out)
    else $error("parity response enable not written");

  a_parity_resp_off: assert property ( // R3
    (wr_lane0 && !cfg_req_in.data[PARITY_RESP_BIT])
      |=> !parity_resp_en_out)
    else $error("parity response enable not cleared");

  a_mdpe_sticky: assert property ( // R13
    (mdpe_reg && !mdpe_clr)
      |=> mdpe_reg)
    else $error("parity flag lost without a clear");

  a_set_beats_clear: assert property ( // R2 R13
    (mdpe_set && mdpe_clr)
      |=> mdpe_reg)
    else $error("parity flag clear won over a new error");

  a_err_msg_sent: assert property ( // R5
    (err_event_in.forward_err && serr_en_reg && !reverse_mode_in)
      |=> err_msg_out)
    else $error("error message not sent");

  a_msg_reverse_off: assert property ( // R5
    reverse_mode_in
      |=> !err_msg_out)
    else $error("error message sent in reverse mode");

  a_serr_forward_off: assert property ( // R6
    !reverse_mode_in
      |=> !system_error_pin_n_oe_out)
    else $error("system error pin driven in forward mode");

  a_serr_pin_level: assert property ( // R6
    system_error_pin_n_oe_out
      |-> !system_error_pin_n_out)
    else $error("system error pin driven high");

  a_intx_follow: assert property ( // R8
    (intx_request_in && !intx_dis_reg)
      |=> intx_assert_out)
    else $error("intx not asserted on request");

  a_intx_needs_req: assert property ( // R8
    intx_assert_out
      |-> $past(intx_request_in))
    else $error("intx asserted without a request");

  a_intx_dis_write: assert property ( // R8
    (wr_lane1 && cfg_req_in.data[INTX_DISABLE_BIT])
      |=> intx_dis_reg ##1 !intx_assert_out)
    else $error("interrupt disable write did not release intx");

  a_pending_set: assert property ( // R9
    intx_request_in
      |=> pend_reg)
    else $error("pending status not set on request");

  a_pending_clear: assert property ( // R9
    (rd_hit && !pend_reg)
      |=> !rd_data_out[INTX_PENDING_BIT])
    else $error("pending status read as one with no request");

  c_parity_set: cover property (par_resp_reg && parity_event_in ##1 mdpe_reg);
  c_parity_clear: cover property (mdpe_reg && mdpe_clr ##1 !mdpe_reg);
  c_serr_drive: cover property (system_error_pin_n_oe_out);
  c_intx_release: cover property (intx_assert_out ##1 intx_dis_reg ##1 !intx_assert_out);
  c_set_beats_clear: cover property (mdpe_set && mdpe_clr ##1 mdpe_reg);
endmodule // primary_command_status_bits

// >>> sim/primary_host_model.sv
// host side of the primary bus: pulled-up error wire and error message counter
// assumes one core clock and synchronous active-high reset
`timescale 1ns/1ps
module primary_host_model (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic err_msg_in,
  input wire logic pin_oe_in,
  input wire logic pin_val_in,
  output logic pin_level_n_out,
  output logic [7:0] msg_count_out
);
  // pull-up when nobody drives the wire
  assign pin_level_n_out = pin_oe_in ? pin_val_in : 1'b1;
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      msg_count_out <= 8'h00;
    end else if (err_msg_in) begin
      msg_count_out <= msg_count_out + 8'h01;
    end
  end
endmodule // primary_host_model

// >>> sim/primary_command_status_bits_tb.sv
// self-checking bench for the primary command/status bits
// assumes the host model beside the block; inputs change on falling edges
`timescale 1ns/1ps
module primary_command_status_bits_tb;
  import cmd_status_pkg::*;
  logic clk = 1'b0, srst = 1'b1, rev = 1'b0, pci = 1'b0, par = 1'b0, intx = 1'b0;
  cfg_req_type req = '0;
  err_event_type ev = '0;
  logic [31:0] rd_data;
  logic rd_valid, pre, emsg, pin_n, oe, ia, lvl_n;
  logic [7:0] mcnt;
  int n_mismatch = 0, cmp_count = 0;
  initial forever #5 clk = ~clk;
  primary_command_status_bits DUT (.core_clk_in(clk), .srst_in(srst), .cfg_req_in(req),
    .reverse_mode_in(rev), .primary_pci_mode_in(pci), .parity_event_in(par),
    .err_event_in(ev), .intx_request_in(intx), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .parity_resp_en_out(pre), .err_msg_out(emsg),
    .system_error_pin_n_out(pin_n), .system_error_pin_n_oe_out(oe), .intx_assert_out(ia));
  primary_host_model host (.core_clk_in(clk), .srst_in(srst), .err_msg_in(emsg),
    .pin_oe_in(oe), .pin_val_in(pin_n), .pin_level_n_out(lvl_n), .msg_count_out(mcnt));
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n = 1);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset(input logic r, input logic p);
    srst = 1'b1;
    rev = r;
    pci = p;
    cyc(16);
    srst = 1'b0;
  endtask
  task automatic wr(input logic [31:0] d, input logic [3:0] be);
    req = '{1'b1, 1'b0, CMD_STATUS_OFFSET, be, d};
    cyc();
    req = '0;
    cyc();
  endtask
  task automatic rd(input logic [11:0] a, input logic hit, input logic [31:0] exp);
    req = '{1'b0, 1'b1, a, 4'hf, 32'h0};
    cyc();
    req = '0;
    chk(32'(rd_valid), 32'(hit));
    chk(rd_data, exp);
    cyc();
  endtask
  task automatic s_reset_image;
    do_reset(1'b0, 1'b1);
    rd(CMD_STATUS_OFFSET, 1'b1, 32'h0010_0000);
    rd(12'h008, 1'b0, 32'h0);
  endtask
  task automatic s_write_bits;
    wr(32'hffff_ffff, 4'hf);
    chk(32'(pre), 32'h1);
    rd(CMD_STATUS_OFFSET, 1'b1, 32'h0010_0540);
  endtask
  task automatic s_parity;
    par = 1'b1;
    cyc();
    par = 1'b0;
    rd(CMD_STATUS_OFFSET, 1'b1, 32'h0110_0540);
    par = 1'b1;
    req = '{1'b1, 1'b0, CMD_STATUS_OFFSET, 4'h8, 32'h0100_0000};
    cyc();
    req = '0;
    par = 1'b0;
    cyc();
    rd(CMD_STATUS_OFFSET, 1'b1, 32'h0110_0540);
    wr(32'h0100_0000, 4'h8);
    rd(CMD_STATUS_OFFSET, 1'b1, 32'h0010_0540);
    wr(32'h0, 4'hf);
    par = 1'b1;
    cyc();
    par = 1'b0;
    rd(CMD_STATUS_OFFSET, 1'b1, 32'h0010_0000);
  endtask
  task automatic s_err_forward;
    ev = '{1'b1, 1'b1};
    cyc();
    chk(32'(emsg), 32'h0);
    ev = '0;
    wr(32'h0000_0100, 4'h2);
    ev = '{1'b1, 1'b1};
    cyc();
    ev = '0;
    chk({30'h0, emsg, oe}, 32'h2);
    cyc();
    chk(32'(mcnt), 32'h1);
  endtask
  task automatic s_intx;
    intx = 1'b1;
    cyc();
    chk(32'(ia), 32'h1);
    rd(CMD_STATUS_OFFSET, 1'b1, 32'h0018_0100);
    wr(32'h0000_0500, 4'h2);
    chk(32'(ia), 32'h0);
    rd(CMD_STATUS_OFFSET, 1'b1, 32'h0018_0500);
    intx = 1'b0;
    cyc();
    rd(CMD_STATUS_OFFSET, 1'b1, 32'h0010_0500);
  endtask
  task automatic s_reverse;
    do_reset(1'b1, 1'b1);
    rd(CMD_STATUS_OFFSET, 1'b1, 32'h00b0_0000);
    ev = '{1'b0, 1'b1};
    cyc();
    chk({31'h0, oe}, 32'h0);
    wr(32'h0000_0100, 4'h2);
    ev = '{1'b1, 1'b1};
    cyc();
    ev = '0;
    chk({30'h0, emsg, lvl_n}, 32'h0);
    do_reset(1'b1, 1'b0);
    rd(CMD_STATUS_OFFSET, 1'b1, 32'h0030_0000);
  endtask
  initial begin
    s_reset_image();
    s_write_bits();
    s_parity();
    s_err_forward();
    s_intx();
    s_reverse();
    print_verdict();
  end
endmodule // primary_command_status_bits_tb
